/* bench/pcs_card_model.sv */
// Card side of the socket: detect pins, shared ready/interrupt pin, read acknowledge.
// Assumes the bench steers insertion, busy and interrupt; host clock only.
`timescale 1ns/1ps
`default_nettype none
module pcs_card_model (
   input wire logic clock,
   input wire logic inserted,
   input wire logic hold_low,
   input wire logic able,
   input wire logic io_read_strobe_n_q,
   output logic card_detect_first,
   output logic card_detect_second,
   output logic ready_irq_n,
   output logic io_read_acknowledge_n
);
   ////////////////////////////////////////////////////////////////
   // Both detect pins grounded inside the card
   assign card_detect_first = !inserted;
   assign card_detect_second = !inserted;
   // Busy write or pending service pulls the shared pin low
   assign ready_irq_n = !hold_low;
   // Acknowledge only a read it can answer; pulled-up pin otherwise
   initial io_read_acknowledge_n = 1'b1;
   always @(posedge clock) begin
      io_read_acknowledge_n <= !(able && !io_read_strobe_n_q);
   end
endmodule
`default_nettype wire

/* bench/pcs_socket_ctrl_monitor.sv */
// Checker on strobes, lanes, select and card reset.
// Bound to pcs_socket_ctrl; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module pcs_socket_ctrl_monitor (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic card_reset_req,
   input wire logic cyc_start,
   input wire logic cyc_attr,
   input wire logic cyc_even,
   input wire logic cyc_odd,
   input wire logic cyc_busy_q,
   input wire logic even_byte_enable_n_q,
   input wire logic odd_byte_enable_n_q,
   input wire logic attr_select_n_q,
   input wire logic mem_read_n_q,
   input wire logic mem_write_n_q,
   input wire logic io_read_strobe_n_q,
   input wire logic io_write_strobe_n_q,
   input wire logic card_reset_q,
   input wire logic [1:0] cyc_kind
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Host cycle taken at this edge
   sequence s_take;
      cyc_start && !cyc_busy_q && !card_reset_req;
   endsequence
   // Strobe falls once setup has run
   property p_strb(k, s);
      s_take ##0 cyc_kind == k |-> ##[7:9] !s;
   endproperty
   a_mem_read: assert property (p_strb(2'h0, mem_read_n_q))
      else $error("no mem read");
   a_mem_write: assert property (p_strb(2'h1, mem_write_n_q))
      else $error("no mem write");
   a_io_read: assert property (p_strb(2'h2, io_read_strobe_n_q))
      else $error("no io read");
   a_io_write: assert property (p_strb(2'h3, io_write_strobe_n_q))
      else $error("no io write");
   a_one_strobe: assert property ($onehot0({~mem_read_n_q, ~mem_write_n_q, ~io_read_strobe_n_q,
      ~io_write_strobe_n_q})) else $error("strobes overlap");
   a_byte_lanes: assert property (s_take |-> ##2 even_byte_enable_n_q == !$past(cyc_even, 2) &&
      odd_byte_enable_n_q == !$past(cyc_odd, 2)) else $error("bad lanes");
   a_common_mem: assert property (s_take ##0 !cyc_kind[1] && !cyc_attr |-> ##1 attr_select_n_q [*8])
      else $error("select on common");
   a_attr_sel: assert property (s_take ##0 (cyc_kind[1] || cyc_attr) |-> ##2 !attr_select_n_q)
      else $error("select missing");
   // Guarded so the reset value is not compared
   a_card_reset: assert property ($past(rst_n) |-> card_reset_q == $past(card_reset_req))
      else $error("card reset lag");
endmodule
bind pcs_socket_ctrl pcs_socket_ctrl_monitor mon_u (.clock(clock), .rst_n(rst_n), .card_reset_req(card_reset_req),
   .cyc_start(cyc_start), .cyc_attr(cyc_attr), .cyc_even(cyc_even), .cyc_odd(cyc_odd), .cyc_busy_q(cyc_busy_q),
   .even_byte_enable_n_q(even_byte_enable_n_q), .odd_byte_enable_n_q(odd_byte_enable_n_q),
   .attr_select_n_q(attr_select_n_q), .mem_read_n_q(mem_read_n_q), .mem_write_n_q(mem_write_n_q),
   .io_read_strobe_n_q(io_read_strobe_n_q), .io_write_strobe_n_q(io_write_strobe_n_q),
   .card_reset_q(card_reset_q), .cyc_kind(cyc_kind));
`default_nettype wire

/* bench/tb_pcs_socket_ctrl.sv */
// Self-checking bench for the socket control block.
// Assumes the card model and the bound checker; 5 ns clock.
`timescale 1ns/1ps
`default_nettype none
module tb_pcs_socket_ctrl;
   logic clock = 0, rst_n = 0, io_mode = 0, card_reset_req = 0, cyc_start = 0, cyc_attr = 0;
   logic cyc_even = 0, cyc_odd = 0, battery_status_first = 1, battery_status_second = 1;
   logic card_audio_in_a = 0, card_audio_in_b = 0, io_mode_b = 0, inserted = 0, hold_low = 0, able = 1;
   logic [1:0] cyc_kind = 0;
   logic card_detect_first, card_detect_second, ready_irq_n, io_read_acknowledge_n;
   logic cyc_busy_q, cyc_done_q, cyc_ack_q, even_byte_enable_n_q, odd_byte_enable_n_q, attr_select_n_q;
   logic mem_read_n_q, mem_write_n_q, io_read_strobe_n_q, io_write_strobe_n_q, card_reset_q;
   logic card_present_q, card_ready_q, card_interrupt_request_q, combined_audio_out_q;
   logic [1:0] battery_state_q;
   int num_errors = 0;
   int checks_done = 0;
   pcs_socket_ctrl dut_u (.clock(clock), .rst_n(rst_n), .io_mode(io_mode), .card_reset_req(card_reset_req),
      .cyc_start(cyc_start), .cyc_kind(cyc_kind), .cyc_attr(cyc_attr), .cyc_even(cyc_even), .cyc_odd(cyc_odd),
      .battery_status_first(battery_status_first), .battery_status_second(battery_status_second),
      .card_detect_first(card_detect_first), .card_detect_second(card_detect_second), .ready_irq_n(ready_irq_n),
      .io_read_acknowledge_n(io_read_acknowledge_n), .card_audio_in_a(card_audio_in_a),
      .card_audio_in_b(card_audio_in_b), .io_mode_b(io_mode_b), .cyc_busy_q(cyc_busy_q), .cyc_done_q(cyc_done_q),
      .cyc_ack_q(cyc_ack_q), .even_byte_enable_n_q(even_byte_enable_n_q), .odd_byte_enable_n_q(odd_byte_enable_n_q),
      .attr_select_n_q(attr_select_n_q), .mem_read_n_q(mem_read_n_q), .mem_write_n_q(mem_write_n_q),
      .io_read_strobe_n_q(io_read_strobe_n_q), .io_write_strobe_n_q(io_write_strobe_n_q),
      .card_reset_q(card_reset_q), .battery_state_q(battery_state_q), .card_present_q(card_present_q),
      .card_ready_q(card_ready_q), .card_interrupt_request_q(card_interrupt_request_q),
      .combined_audio_out_q(combined_audio_out_q));
   pcs_card_model card_u (.clock(clock), .inserted(inserted), .hold_low(hold_low), .able(able),
      .io_read_strobe_n_q(io_read_strobe_n_q), .card_detect_first(card_detect_first),
      .card_detect_second(card_detect_second), .ready_irq_n(ready_irq_n),
      .io_read_acknowledge_n(io_read_acknowledge_n));
   initial forever #2.5 clock = ~clock;
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [3:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Every cycle kind: only its own strobe, ack only on io read
   task automatic t_cycles;
      logic [3:0] low;
      logic ack;
      for (int k = 0; k < 4; k++) begin
         low = 0;
         @(posedge clock);
         cyc_start <= 1;
         cyc_kind <= k[1:0];
         cyc_attr <= k[0];
         cyc_even <= 1;
         cyc_odd <= k[1];
         @(posedge clock);
         cyc_start <= 0;
         for (int i = 0; i < 60 && cyc_done_q !== 1'b1; i++) begin
            @(negedge clock);
            low |= ~{mem_read_n_q, mem_write_n_q, io_read_strobe_n_q, io_write_strobe_n_q};
            if (i == 20) ack = cyc_ack_q;
         end
         chk("done", cyc_done_q, 1);
         chk("strobes", low, 4'h8 >> k);
         chk("ack", ack, k == 2);
      end
   endtask
   // Card pins reach the status outputs a cycle later
   task automatic t_status;
      for (int j = 0; j < 8; j++) begin
         @(posedge clock);
         battery_status_first <= j[1];
         battery_status_second <= j[0];
         inserted <= j[0];
         hold_low <= j[1];
         card_audio_in_a <= j[0];
         card_audio_in_b <= j[1];
         io_mode_b <= j[0];
         io_mode <= j[2];
         repeat (2) @(negedge clock);
         chk("battery", battery_state_q, j[2] ? 2'h0 : (j[1] ? {1'b0, !j[0]} : 2'h2));
         chk("present", card_present_q, j[0]);
         chk("ready", card_ready_q, !j[2] && !j[1]);
         chk("irq", card_interrupt_request_q, j[2] && j[1]);
         chk("audio", combined_audio_out_q, (j[2] & j[0]) ^ (j[0] & j[1]));
      end
   endtask
   // Card reset in mid-strobe drops the strobe at once
   task automatic t_abort;
      @(posedge clock);
      cyc_start <= 1;
      cyc_kind <= 2'h3;
      @(posedge clock);
      cyc_start <= 0;
      repeat (12) @(posedge clock);
      card_reset_req <= 1;
      repeat (2) @(negedge clock);
      chk("abort", {io_write_strobe_n_q, card_reset_q, cyc_busy_q}, 3'h6);
      @(posedge clock);
      card_reset_req <= 0;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1;
      t_cycles;
      t_status;
      t_abort;
      t_cycles;
      print_verdict;
   end
   // Traffic takes some 400 cycles; allow ten times that
   initial begin
      #20000;
      num_errors++;
      print_verdict;
   end
endmodule
`default_nettype wire

/* verilog/pcs_defines.vh */
// Constants for the 16-bit card socket control block.
// Assumes inclusion by bare name from verilog/.
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH
// Battery condition codes
`define PCS_BATT_GOOD 2'h0
`define PCS_BATT_WEAK 2'h1
`define PCS_BATT_DEAD 2'h2
// Host cycle kinds
`define PCS_CYC_MEM_RD 2'h0
`define PCS_CYC_MEM_WR 2'h1
`define PCS_CYC_IO_RD 2'h2
`define PCS_CYC_IO_WR 2'h3
// Sequencer states
`define PCS_ST_IDLE 2'h0
`define PCS_ST_SETUP 2'h1
`define PCS_ST_STROBE 2'h2
`define PCS_ST_HOLD 2'h3
// Strobe timing, ns, and cycle counts at 5 ns
`define PCS_CLK_NS 5
`define PCS_SETUP_NS 30
`define PCS_STROBE_NS 150
`define PCS_HOLD_NS 20
// Counter loads: 6 setup, 30 strobe and 4 hold cycles, each less one
`define PCS_SETUP_LOAD 8'h05
`define PCS_STROBE_LOAD 8'h1d
`define PCS_HOLD_LOAD 8'h03
`define PCS_CNT_ZERO 8'h00
`define PCS_CNT_W 8
`endif

/* verilog/pcs_socket_ctrl.v */
// Control strobes and status decode for one 16-bit card socket, audio merged for two.
// Assumes card inputs already synchronous to clock; one host cycle at a time.
// Assumes the host waits for the done pulse before the next request.
// Assumes socket B status is handled elsewhere; only its audio comes here.
// Function
// RL1 - Decode battery pins: both high good, second low weak, first low dead.
// RL2 - Card audio counts only when socket is in I/O interface mode.
// RL3 - Merge socket A and socket B audio onto one output pin.
// RL4 - Card grounds both detect lines; report them as socket status.
// RL5 - First card enable selects even bytes, second selects odd bytes.
// RL6 - Card acknowledges input only when it can answer current I/O read.
// RL7 - Assert I/O read strobe during host I/O read cycles.
// RL8 - Drive I/O write strobe low during host I/O write cycles.
// RL9 - Drive output enable low during host memory read cycles.
// RL10 - Memory card holds ready low while busy, high when able.
// RL11 - Shared ready/interrupt pin means ready only in memory-only mode.
// RL12 - In I/O mode card pulls interrupt low to request service.
// RL13 - Attribute select stays high for all common memory accesses.
// RL14 - Attribute select with memory strobes means attribute memory, else I/O.
// RL15 - Card reset output forces a hard reset while asserted.
// RL16 - Memory write strobe latches write data into memory cards.
// RL17 - Never more than one of the four strobes active at once.
`include "pcs_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module pcs_socket_ctrl (
   input wire clock,
   input wire rst_n,
   input wire io_mode,
   input wire card_reset_req,
   input wire cyc_start,
   input wire [1:0] cyc_kind,
   input wire cyc_attr,
   input wire cyc_even,
   input wire cyc_odd,
   input wire battery_status_first,
   input wire battery_status_second,
   input wire card_detect_first,
   input wire card_detect_second,
   input wire ready_irq_n,
   input wire io_read_acknowledge_n,
   input wire card_audio_in_a,
   input wire card_audio_in_b,
   input wire io_mode_b,
   output reg cyc_busy_q,
   output reg cyc_done_q,
   output reg cyc_ack_q,
   output reg even_byte_enable_n_q,
   output reg odd_byte_enable_n_q,
   output reg attr_select_n_q,
   output reg mem_read_n_q,
   output reg mem_write_n_q,
   output reg io_read_strobe_n_q,
   output reg io_write_strobe_n_q,
   output reg card_reset_q,
   output reg [1:0] battery_state_q,
   output reg card_present_q,
   output reg card_ready_q,
   output reg card_interrupt_request_q,
   output reg combined_audio_out_q
);

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [`PCS_CNT_W-1:0] cnt_q;
   reg [`PCS_CNT_W-1:0] cnt_d;
   reg [1:0] kind_q;
   reg attr_q;
   reg even_q;
   reg odd_q;
   reg ack_seen_q;
   reg [1:0] batt_d;

   ////////////////////////////////////////////////////////////////
   // Cycle sequencer: setup, strobe, hold; one cycle at a time
   // Timing at 5 ns: 6 setup, 30 strobe and 4 hold cycles;
   // counters load one less since the zero count is spent as well
   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         `PCS_ST_IDLE: begin
            if (cyc_start && !card_reset_req) begin
               state_d = `PCS_ST_SETUP;
               cnt_d = `PCS_SETUP_LOAD;
            end
         end
         `PCS_ST_SETUP: begin
            if (cnt_q == `PCS_CNT_ZERO) begin
               state_d = `PCS_ST_STROBE;
               cnt_d = `PCS_STROBE_LOAD;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         `PCS_ST_STROBE: begin
            if (cnt_q == `PCS_CNT_ZERO) begin
               state_d = `PCS_ST_HOLD;
               cnt_d = `PCS_HOLD_LOAD;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         `PCS_ST_HOLD: begin
            if (cnt_q == `PCS_CNT_ZERO) begin
               state_d = `PCS_ST_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: begin
            state_d = `PCS_ST_IDLE;
            cnt_d = `PCS_CNT_ZERO;
         end
      endcase
      // Card reset cuts any cycle, so strobes rise at the next edge
      if (card_reset_req) begin
         state_d = `PCS_ST_IDLE;
         cnt_d = `PCS_CNT_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Phase decode shared by the pin drivers
   wire take_now;
   wire run_next;
   wire strobe_next;
   wire [1:0] kind_next;
   wire attr_next;
   wire even_next;
   wire odd_next;
   wire select_next;

   // A request is taken only from idle and outside card reset
   assign take_now = (state_q == `PCS_ST_IDLE) && cyc_start && !card_reset_req;
   // Next state already carries the card reset abort
   assign run_next = (state_d != `PCS_ST_IDLE);
   // Strobe phase next; the captured kind picks which strobe
   assign strobe_next = (state_d == `PCS_ST_STROBE);
   // On the taking edge the captured copies are not loaded yet
   assign kind_next = take_now ? cyc_kind : kind_q;
   assign attr_next = take_now ? cyc_attr : attr_q;
   assign even_next = take_now ? cyc_even : even_q;
   assign odd_next = take_now ? cyc_odd : odd_q;
   // I/O space always asserts select; memory only for attribute space
   assign select_next = attr_next || kind_next[1]; // RL13 RL14

   // Sequencer flops; card reset is folded into the next state
   always @(posedge clock) begin
      if (!rst_n) begin
         state_q <= `PCS_ST_IDLE;
         cnt_q <= `PCS_CNT_ZERO;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Request captured at the taking edge and held to the end of the cycle
   always @(posedge clock) begin
      // Card reset clears the request so nothing replays after it
      if (!rst_n || card_reset_req) begin
         kind_q <= `PCS_CYC_MEM_RD;
         attr_q <= 1'b0;
         even_q <= 1'b0;
         odd_q <= 1'b0;
      end else if (take_now) begin
         kind_q <= cyc_kind;
         attr_q <= cyc_attr;
         even_q <= cyc_even;
         odd_q <= cyc_odd;
      end
   end

   // Card claims the read only for an address it decodes
   always @(posedge clock) begin
      if (!rst_n || card_reset_req || take_now) begin
         ack_seen_q <= 1'b0;
      end else if (state_q == `PCS_ST_STROBE && kind_q == `PCS_CYC_IO_RD && !io_read_acknowledge_n) begin
         ack_seen_q <= 1'b1; // RL6
      end
   end

   ////////////////////////////////////////////////////////////////
   // Next pin values; all strobes come from one decoded kind so they stay exclusive
   reg busy_d;
   reg done_d;
   reg ack_d;
   reg even_n_d;
   reg odd_n_d;
   reg select_n_d;
   reg mem_read_n_d;
   reg mem_write_n_d;
   reg io_read_n_d;
   reg io_write_n_d;

   always @* begin
      busy_d = run_next;
      // Pulse on the last hold cycle; a cut cycle ends without it
      done_d = (state_q == `PCS_ST_HOLD) && (cnt_q == `PCS_CNT_ZERO) && !card_reset_req;
      // Acknowledge counts for I/O reads only; level stays until the next start or a card reset
      ack_d = ack_seen_q || (state_q == `PCS_ST_STROBE && kind_q == `PCS_CYC_IO_RD && !io_read_acknowledge_n);
      // Byte lanes held across setup, strobe and hold
      even_n_d = !(run_next && even_next); // RL5
      odd_n_d = !(run_next && odd_next); // RL5
      select_n_d = !(run_next && select_next); // RL13 RL14
      // One strobe at most, only in the strobe phase
      mem_read_n_d = !(strobe_next && kind_next == `PCS_CYC_MEM_RD); // RL9 RL17
      mem_write_n_d = !(strobe_next && kind_next == `PCS_CYC_MEM_WR); // RL16 RL17
      io_read_n_d = !(strobe_next && kind_next == `PCS_CYC_IO_RD); // RL7 RL17
      io_write_n_d = !(strobe_next && kind_next == `PCS_CYC_IO_WR); // RL8 RL17
   end

   // Pin flops; strobes idle high so a card sees no access in reset
   always @(posedge clock) begin
      if (!rst_n) begin
         // Host side quiet, every card strobe high, card held in reset
         cyc_busy_q <= 1'b0;
         cyc_done_q <= 1'b0;
         cyc_ack_q <= 1'b0;
         even_byte_enable_n_q <= 1'b1;
         odd_byte_enable_n_q <= 1'b1;
         attr_select_n_q <= 1'b1;
         mem_read_n_q <= 1'b1;
         mem_write_n_q <= 1'b1;
         io_read_strobe_n_q <= 1'b1;
         io_write_strobe_n_q <= 1'b1;
         card_reset_q <= 1'b1;
      end else begin
         // Host handshake
         cyc_busy_q <= busy_d;
         cyc_done_q <= done_d;
         cyc_ack_q <= ack_d;
         // Card pins
         even_byte_enable_n_q <= even_n_d; // RL5
         odd_byte_enable_n_q <= odd_n_d; // RL5
         attr_select_n_q <= select_n_d; // RL13 RL14
         mem_read_n_q <= mem_read_n_d; // RL9
         mem_write_n_q <= mem_write_n_d; // RL16
         io_read_strobe_n_q <= io_read_n_d; // RL7
         io_write_strobe_n_q <= io_write_n_d; // RL8
         card_reset_q <= card_reset_req; // RL15
      end
   end

   ////////////////////////////////////////////////////////////////
   // Battery decode; first pin low overrides the second
   always @* begin
      if (!battery_status_first) begin
         batt_d = `PCS_BATT_DEAD; // RL1
      end else if (!battery_status_second) begin
         batt_d = `PCS_BATT_WEAK; // RL1
      end else begin
         batt_d = `PCS_BATT_GOOD; // RL1
      end
   end

   ////////////////////////////////////////////////////////////////
   // Status next values; pins are meaningful per interface mode only
   reg [1:0] battery_d;
   reg present_d;
   reg ready_d;
   reg irq_d;
   reg audio_a_gated;
   reg audio_b_gated;
   reg audio_d;

   always @* begin
      // Battery pins double as audio in I/O mode, so decode memory mode only
      battery_d = io_mode ? `PCS_BATT_GOOD : batt_d; // RL1
      // Both grounded lines low means fully seated
      present_d = !card_detect_first && !card_detect_second; // RL4
      // Shared pin is ready in memory mode, low-active request in I/O mode
      ready_d = !io_mode && ready_irq_n; // RL11
      irq_d = io_mode && !ready_irq_n; // RL11
      // Each socket's audio only counts in its own I/O mode
      audio_a_gated = io_mode && card_audio_in_a; // RL2
      audio_b_gated = io_mode_b && card_audio_in_b; // RL2
      // Binary audio mixed by exclusive-or
      audio_d = audio_a_gated ^ audio_b_gated; // RL3
   end

   // Status flops; one cycle behind the card pins
   always @(posedge clock) begin
      if (!rst_n) begin
         // Nothing reported until reset is released
         battery_state_q <= `PCS_BATT_GOOD;
         card_present_q <= 1'b0;
         card_ready_q <= 1'b0;
         card_interrupt_request_q <= 1'b0;
         combined_audio_out_q <= 1'b0;
      end else begin
         battery_state_q <= battery_d;
         card_present_q <= present_d;
         card_ready_q <= ready_d;
         card_interrupt_request_q <= irq_d;
         combined_audio_out_q <= audio_d;
      end
   end

endmodule
`default_nettype wire
